// *** common/wdt_map.svh ***
// Register offsets, field positions, reset values and counts for the watchdog block
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// Register byte offsets on the APB
`define WDT_ADDR_W          12
`define WDT_OFS_CTRL        12'h0d8
`define WDT_OFS_COUNT       12'h0dc
`define WDT_OFS_EXT_IRQ_EN  12'h0e8
`define WDT_OFS_IRQ_STATUS  12'h0f0
`define WDT_OFS_IRQ_MASK    12'h0f4
`define WDT_OFS_TA_LOCK     12'h0fc

// Control/status field positions
`define WDT_BIT_RESTART     0
`define WDT_BIT_RST_EN      1
`define WDT_BIT_RST_FLAG    2
`define WDT_BIT_TO_FLAG     3
`define WDT_BIT_TO_IRQ_EN   4

// Interrupt status/mask field positions
`define WDT_IRQ_BIT_TIMEOUT 0
`define WDT_IRQ_BIT_RESET   1

// Reset values
`define WDT_CTRL_RST        8'h00
`define WDT_EXT_IRQ_EN_RST  8'h00
`define WDT_IRQ_MASK_RST    2'h0

// Counter and lock constants
`define WDT_CNT_W           30
`define WDT_TERMINAL        30'h3fffffff
`define WDT_REDUCED_DIV     16
`define WDT_TA_KEY1         8'haa
`define WDT_TA_KEY2         8'h55

`endif

// *** common/wdt_pkg.sv ***
// Types shared by the watchdog modules
package wdt_pkg;

  // Timed-access lock states
  typedef enum logic [1:0] {
    WDT_LOCKED = 2'b00,
    WDT_HALF   = 2'b01,
    WDT_OPEN   = 2'b10
  } wdt_lock_state_type;

endpackage

// *** verilog/wdt_counter.sv ***
// Watchdog 30-bit count chain with reduced-rate prescaler and expiry detect
`timescale 1ns/100ps
`default_nettype none
`include "wdt_map.svh"

module wdt_counter import wdt_pkg::*; #(
  parameter int                     CNT_W       = `WDT_CNT_W,
  parameter logic [`WDT_CNT_W-1:0]  TERMINAL    = `WDT_TERMINAL,
  parameter int                     REDUCED_DIV = `WDT_REDUCED_DIV
) (
  input  wire logic             ref_clk,      // Core clock
  input  wire logic             rst_n,        // Async reset, active low
  input  wire logic             cpu_tick,     // One pulse per CPU clock
  input  wire logic             halted,       // Idle or stop mode
  input  wire logic             reduced,      // Reduced-clock mode
  input  wire logic             restart,      // Clear count to zero
  output logic [CNT_W-1:0]      count,        // Present count
  output logic                  expire        // Terminal reached, pulse
);

  logic [CNT_W-1:0] count_r;
  logic [7:0]       pre_r;
  wire              pre_wrap;
  wire              advance;
  wire              at_term;

  // Slow mode only lets every REDUCED_DIV-th CPU tick through
  assign pre_wrap = (pre_r == 8'(REDUCED_DIV - 1));
  assign advance  = cpu_tick && !halted && (!reduced || pre_wrap);
  assign at_term  = (count_r == TERMINAL);
  assign expire   = advance && at_term && !restart;
  assign count    = count_r;

  // Prescaler runs only while reduced mode counts CPU ticks
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= 8'h00;
    end else if (!reduced || halted) begin
      pre_r <= 8'h00;
    end else if (cpu_tick) begin
      pre_r <= pre_wrap ? 8'h00 : pre_r + 8'h01;
    end
  end

  // Count: restart first, wrap to zero at terminal
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
    end else if (restart) begin
      count_r <= '0;
    end else if (advance) begin
      count_r <= at_term ? '0 : count_r + CNT_W'(1);
    end
  end

endmodule
`default_nettype wire

// *** verilog/wdt_ta_lock.sv ***
// Timed-access lock: two key writes open one protected write
`timescale 1ns/100ps
`default_nettype none
`include "wdt_map.svh"

module wdt_ta_lock import wdt_pkg::*; (
  input  wire logic        ref_clk,     // Core clock
  input  wire logic        rst_n,       // Async reset, active low
  input  wire logic        key_wr,      // Write to lock register
  input  wire logic [7:0]  key_data,    // Written key byte
  input  wire logic        consume,     // Protected write taken
  output logic             unlocked     // Lock is open
);

  wdt_lock_state_type state_r;
  wdt_lock_state_type state_nxt;

  assign unlocked = (state_r == WDT_OPEN);

  // A wrong key always drops back to locked
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      WDT_LOCKED: begin
        if (key_wr) begin
          state_nxt = (key_data == `WDT_TA_KEY1) ? WDT_HALF : WDT_LOCKED;
        end
      end
      WDT_HALF: begin
        if (key_wr) begin
          state_nxt = (key_data == `WDT_TA_KEY2) ? WDT_OPEN : WDT_LOCKED;
        end
      end
      WDT_OPEN: begin
        if (consume || key_wr) begin
          state_nxt = WDT_LOCKED;
        end
      end
      default: begin
        state_nxt = WDT_LOCKED;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= WDT_LOCKED;
    end else begin
      state_r <= state_nxt;
    end
  end

endmodule
`default_nettype wire

// *** verilog/wdt_top.sv ***
// Watchdog top: APB register file, flags, reset request and interrupts
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "wdt_map.svh"

module wdt_top import wdt_pkg::*; #(
  parameter logic [`WDT_CNT_W-1:0] TERMINAL    = `WDT_TERMINAL,
  parameter int                    REDUCED_DIV = `WDT_REDUCED_DIV
) (
  input  wire logic                   ref_clk,        // 250 MHz core clock
  input  wire logic                   rst_n,          // Hardware reset, active low
  input  wire logic                   psel,           // APB select
  input  wire logic                   penable,        // APB access phase
  input  wire logic                   pwrite,         // APB write
  input  wire logic [`WDT_ADDR_W-1:0] paddr,          // APB byte address
  input  wire logic [31:0]            pwdata,         // APB write data
  input  wire logic [3:0]             pstrb,          // APB byte strobes
  output logic [31:0]                 prdata,         // APB read data
  output logic                        pready,         // APB ready
  output logic                        pslverr,        // APB error
  input  wire logic                   cpu_tick,       // CPU clock pulse
  input  wire logic                   idle_mode,      // CPU idle mode
  input  wire logic                   stop_mode,      // CPU stop mode
  input  wire logic                   reduced_clock_mode, // Slowed CPU clock
  output logic                        timeout_irq_req,    // CPU interrupt request
  output logic                        sys_reset_req,  // System reset, pulse
  output logic                        irq             // Masked event interrupt
);

  localparam int CNT_W = `WDT_CNT_W;

  // Register map, one word per register, fields in the low bits:
  //   control/status  bit3 timeout flag, bit2 reset-cause flag,
  //                   bit1 reset enable, bit0 restart (always reads zero)
  //   count           live counter value, read only
  //   extended enable bit4 gates the CPU timeout request
  //   event status    bit0 timeout, bit1 reset request; write one clears
  //   event mask      same layout as event status
  //   lock            two key writes open one restart; bit0 reads open
  // Both flags clear on a written zero, so a read-modify-write that
  // copies a flag back as one never loses an event raised meanwhile.
  // Bus timing: setup, first access cycle, then ready in the second
  // access cycle; every answer, error included, has one wait state.
  // Writes act only when byte lane 0 is strobed; other lanes hold
  // no writable field, so a lane-0-less write is dropped quietly.

  // Register state
  logic             rst_en_r;
  logic             to_flag_r;
  logic             rst_flag_r;
  logic [7:0]       ext_irq_en_r;
  logic [1:0]       irq_status_r;
  logic [1:0]       irq_mask_r;
  logic [31:0]      prdata_r;
  logic             pready_r;
  logic             pslverr_r;
  logic             sys_reset_req_r;
  logic             timeout_irq_req_r;
  logic             irq_r;

  // Counter and lock
  logic [CNT_W-1:0] count;
  logic             expire;
  logic             unlocked;

  // APB phase decode
  wire access_first = psel && penable && !pready_r;
  wire access_done  = psel && penable && pready_r;
  wire wr_done      = access_done && pwrite;
  wire lane0        = pstrb[0];

  // Address decode
  wire sel_ctrl     = (paddr == `WDT_OFS_CTRL);
  wire sel_count    = (paddr == `WDT_OFS_COUNT);
  wire sel_ext_en   = (paddr == `WDT_OFS_EXT_IRQ_EN);
  wire sel_status   = (paddr == `WDT_OFS_IRQ_STATUS);
  wire sel_mask     = (paddr == `WDT_OFS_IRQ_MASK);
  wire sel_ta       = (paddr == `WDT_OFS_TA_LOCK);
  wire mapped       = sel_ctrl || sel_count || sel_ext_en || sel_status
                      || sel_mask || sel_ta;

  // Per-register write strobes; byte lane 0 carries every writable field
  wire wr_ctrl      = wr_done && sel_ctrl && lane0;
  wire wr_ext_en    = wr_done && sel_ext_en && lane0;
  wire wr_status    = wr_done && sel_status && lane0;
  wire wr_mask      = wr_done && sel_mask && lane0;
  wire wr_ta        = wr_done && sel_ta && lane0;

  // Restart needs an open lock; any control write spends the lock
  // A control write without the restart bit still relocks, so every
  // restart costs a fresh key pair; a runaway loop cannot keep it open
  wire restart      = wr_ctrl && pwdata[`WDT_BIT_RESTART] && unlocked;
  wire halted       = idle_mode || stop_mode;

  // Expiry effects
  // A restart in the expiry's own cycle wins: the count clears and no
  // flag, status or reset request follows
  wire reset_fire   = expire && rst_en_r;
  wire to_clr       = wr_ctrl && !pwdata[`WDT_BIT_TO_FLAG];
  wire rstf_clr     = wr_ctrl && !pwdata[`WDT_BIT_RST_FLAG];

  // Event sources for the sticky status
  wire [1:0] irq_events = {reset_fire, expire};
  wire [1:0] irq_w1c    = wr_status ? pwdata[1:0] : 2'h0;

  // Interrupt levels; the CPU request follows the flag, not the event,
  // so a pending timeout stays visible until software clears the flag
  wire timeout_irq_req_nxt = to_flag_r && ext_irq_en_r[`WDT_BIT_TO_IRQ_EN];
  wire irq_nxt             = |(irq_status_r & irq_mask_r);

  // Read views
  wire [7:0] ctrl_view;
  assign ctrl_view = {4'h0, to_flag_r, rst_flag_r, rst_en_r, 1'b0};

  // Each register widened to the bus; unused upper bits read zero
  wire [31:0] view_ctrl   = {24'h00_0000, ctrl_view};
  wire [31:0] view_count  = {2'h0, count};
  wire [31:0] view_ext_en = {24'h00_0000, ext_irq_en_r};
  wire [31:0] view_status = {30'h0000_0000, irq_status_r};
  wire [31:0] view_mask   = {30'h0000_0000, irq_mask_r};
  wire [31:0] view_lock   = {31'h0000_0000, unlocked};

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_ctrl) begin
      rd_mux = view_ctrl;
    end else if (sel_count) begin
      rd_mux = view_count;
    end else if (sel_ext_en) begin
      rd_mux = view_ext_en;
    end else if (sel_status) begin
      rd_mux = view_status;
    end else if (sel_mask) begin
      rd_mux = view_mask;
    end else if (sel_ta) begin
      rd_mux = view_lock;
    end
  end

  // Count chain; restart and terminal wrap live here
  // Reduced mode is divided inside the chain, so cpu_tick keeps its full
  // rate there; a source that also slowed the tick would divide twice
  wdt_counter #(
    .CNT_W       (CNT_W),
    .TERMINAL    (TERMINAL),
    .REDUCED_DIV (REDUCED_DIV)
  ) u_counter (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .cpu_tick (cpu_tick),
    .halted   (halted),
    .reduced  (reduced_clock_mode),
    .restart  (restart),
    .count    (count),
    .expire   (expire)
  );

  // Two-key lock guarding the restart bit
  wdt_ta_lock u_lock (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .key_wr   (wr_ta),
    .key_data (pwdata[7:0]),
    .consume  (wr_ctrl),
    .unlocked (unlocked)
  );

  // APB answer: one wait state keeps all bus outputs registered
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= access_first;
    end
  end

  // Error rides with ready for any address outside the map
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= access_first && !mapped;
    end
  end

  // Read data captured once per access; a write answer carries zero
  // so stale read data never rides on a write or an error
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (access_first) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  // Reset enable is plain read/write
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_en_r <= 1'b0;
    end else if (wr_ctrl) begin
      rst_en_r <= pwdata[`WDT_BIT_RST_EN];
    end
  end

  // Timeout flag: expiry sets it, only rst_n or a software zero clears it;
  // an expiry in the same cycle as the clear wins so no event is lost
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      to_flag_r <= 1'b0;
    end else if (expire) begin
      to_flag_r <= 1'b1;
    end else if (to_clr) begin
      to_flag_r <= 1'b0;
    end
  end

  // Reset-cause flag: only a hardware reset or software clears it
  // The system reset requested here is applied outside, so the flag
  // survives it; of the resets only rst_n, the hardware reset, clears it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_flag_r <= 1'b0;
    end else if (reset_fire) begin
      rst_flag_r <= 1'b1;
    end else if (rstf_clr) begin
      rst_flag_r <= 1'b0;
    end
  end

  // Extended interrupt enable; only bit 4 matters to this block
  // The other seven bits are kept for software to read back unchanged
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_irq_en_r <= `WDT_EXT_IRQ_EN_RST;
    end else if (wr_ext_en) begin
      ext_irq_en_r <= pwdata[7:0];
    end
  end

  // Sticky event status, write one to clear, set wins
  // A clear landing on an event's own cycle is ignored, so no event
  // slips between a status read and its clear
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_status
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          irq_status_r[gi] <= 1'b0;
        end else if (irq_events[gi]) begin
          irq_status_r[gi] <= 1'b1;
        end else if (irq_w1c[gi]) begin
          irq_status_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Event mask
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_r <= `WDT_IRQ_MASK_RST;
    end else if (wr_mask) begin
      irq_mask_r <= pwdata[1:0];
    end
  end

  // Reset request: one cycle per expiry with reset enabled
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_reset_req_r <= 1'b0;
    end else begin
      sys_reset_req_r <= reset_fire;
    end
  end

  // CPU interrupt follows the flag, gated by the extended enable bit;
  // registered, so it lags the flag by one cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timeout_irq_req_r <= 1'b0;
    end else begin
      timeout_irq_req_r <= timeout_irq_req_nxt;
    end
  end

  // Masked event interrupt level
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // Outputs straight from flops
  // No output is decoded combinationally, so none can glitch
  assign prdata          = prdata_r;
  assign pready          = pready_r;
  assign pslverr         = pslverr_r;
  assign sys_reset_req   = sys_reset_req_r;
  assign timeout_irq_req = timeout_irq_req_r;
  assign irq             = irq_r;

endmodule
`default_nettype wire

// *** tb/wdt_monitor.sv ***
// Port-level concurrent checks for the watchdog top
`timescale 1ns/100ps
`default_nettype none
`include "wdt_map.svh"

module wdt_monitor #(
  parameter logic [`WDT_CNT_W-1:0] TERMINAL    = `WDT_TERMINAL,
  parameter int                    REDUCED_DIV = `WDT_REDUCED_DIV
) (
  input wire logic                   ref_clk,         // Core clock
  input wire logic                   rst_n,           // Hardware reset, active low
  input wire logic                   psel,            // APB select
  input wire logic                   penable,         // APB access phase
  input wire logic                   pwrite,          // APB write
  input wire logic [`WDT_ADDR_W-1:0] paddr,           // APB byte address
  input wire logic [31:0]            prdata,          // APB read data
  input wire logic                   pready,          // APB ready
  input wire logic                   pslverr,         // APB error
  input wire logic                   cpu_tick,        // CPU clock pulse
  input wire logic                   idle_mode,       // CPU idle mode
  input wire logic                   stop_mode,       // CPU stop mode
  input wire logic                   timeout_irq_req, // CPU interrupt request
  input wire logic                   sys_reset_req,   // System reset pulse
  input wire logic                   irq              // Masked event interrupt
);
  // One domain, so clock and disable are given once
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // The reset request lags its advancing tick by one edge, so the depth four covers it with margin
  property p_halt_quiet;
    (idle_mode || stop_mode) [*4] |-> !sys_reset_req;
  endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("reset request while halted");
  property p_no_tick;
    !cpu_tick [*4] |-> !sys_reset_req;
  endproperty
  a_no_tick: assert property (p_no_tick) else $error("reset request without a tick");
  property p_reset_once;
    sys_reset_req |=> !sys_reset_req;
  endproperty
  a_reset_once: assert property (p_reset_once) else $error("reset request too long");
  property p_ctrl_read;
    pready && !pwrite && !pslverr && paddr == `WDT_OFS_CTRL |-> prdata[31:5] == 27'h0 && !prdata[0];
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control read bits wrong");
  property p_count_read;
    pready && !pwrite && paddr == `WDT_OFS_COUNT |-> prdata[31:30] == 2'h0;
  endproperty
  a_count_read: assert property (p_count_read) else $error("count wider than 30 bits");
  property p_quiet_start;
    $rose(rst_n) |-> !sys_reset_req && !irq && !timeout_irq_req;
  endproperty
  a_quiet_start: assert property (p_quiet_start) else $error("outputs active after reset");
  property p_ready_one;
    pready |=> !pready;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("ready longer than a cycle");
  property p_wait_state;
    psel && $rose(penable) |-> !pready ##1 pready;
  endproperty
  a_wait_state: assert property (p_wait_state) else $error("wait state count wrong");
  property p_err_zero;
    pready && pslverr |-> prdata == 32'h0 && psel && penable;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error answer carries data");
endmodule
`default_nettype wire

// *** tb/tb_watchdog_timer_30bit.sv ***
// Self-checking bench for the watchdog block over APB
`timescale 1ns/100ps
`default_nettype none
`include "wdt_map.svh"

module tb_watchdog_timer_30bit;
  // Short terminal count keeps every expiry within a few dozen ticks
  localparam logic [29:0] TERM = 30'h0000014;
  localparam int          DIV  = 4;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic [31:0] prdata;
  logic        pready, pslverr, timeout_irq_req, sys_reset_req, irq;
  logic        cpu_tick = 1'b0;
  logic        idle_mode = 1'b0;
  logic        stop_mode = 1'b0;
  logic        reduced_clock_mode = 1'b0;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          n_rst_req = 0;

  always #2 ref_clk = ~ref_clk;

  wdt_top #(.TERMINAL(TERM), .REDUCED_DIV(DIV)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_tick(cpu_tick), .idle_mode(idle_mode), .stop_mode(stop_mode),
    .reduced_clock_mode(reduced_clock_mode), .timeout_irq_req(timeout_irq_req),
    .sys_reset_req(sys_reset_req), .irq(irq));

  // Counts reset pulses so a doubled pulse shows up as a wrong total
  always @(posedge ref_clk) if (sys_reset_req === 1'b1) n_rst_req++;

  task automatic test_done;
    if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // One APB transfer; waits for ready, only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk_val(q, exp);
    chk_bit(e, exp_err);
  endtask

  // Registered outputs trail a write by one edge; give them time
  task automatic settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  task automatic tick(input int n);
    @(posedge ref_clk);
    cpu_tick <= 1'b1;
    repeat (n) @(posedge ref_clk);
    cpu_tick <= 1'b0;
  endtask

  task automatic unlock;
    wr(`WDT_OFS_TA_LOCK, 32'haa);
    wr(`WDT_OFS_TA_LOCK, 32'h55);
  endtask

  // Main sequence: reset values, restart lock, halts, expiry, flags, reset source
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_chk(`WDT_OFS_CTRL, 32'h0, 1'b0);
    rd_chk(`WDT_OFS_EXT_IRQ_EN, 32'h0, 1'b0);
    rd_chk(`WDT_OFS_IRQ_MASK, 32'h0, 1'b0);
    rd_chk(12'h0a0, 32'h0, 1'b1);
    // A write without byte lane 0 must leave the register alone
    pstrb <= 4'he;
    wr(`WDT_OFS_EXT_IRQ_EN, 32'hff);
    pstrb <= 4'hf;
    rd_chk(`WDT_OFS_EXT_IRQ_EN, 32'h0, 1'b0);
    tick(7);
    rd_chk(`WDT_OFS_COUNT, 32'd7, 1'b0);
    wr(`WDT_OFS_CTRL, 32'h01);
    rd_chk(`WDT_OFS_COUNT, 32'd7, 1'b0);
    // A wrong second key drops the lock back, so restart stays blocked
    wr(`WDT_OFS_TA_LOCK, 32'haa);
    wr(`WDT_OFS_TA_LOCK, 32'h12);
    wr(`WDT_OFS_TA_LOCK, 32'h55);
    rd_chk(`WDT_OFS_TA_LOCK, 32'h0, 1'b0);
    wr(`WDT_OFS_CTRL, 32'h01);
    rd_chk(`WDT_OFS_COUNT, 32'd7, 1'b0);
    unlock;
    rd_chk(`WDT_OFS_TA_LOCK, 32'h1, 1'b0);
    wr(`WDT_OFS_CTRL, 32'h01);
    rd_chk(`WDT_OFS_COUNT, 32'd0, 1'b0);
    rd_chk(`WDT_OFS_TA_LOCK, 32'h0, 1'b0);
    rd_chk(`WDT_OFS_CTRL, 32'h0, 1'b0);
    // Idle and stop freeze the count; reduced mode divides the ticks
    for (int m = 0; m < 3; m++) begin
      idle_mode <= (m == 0);
      stop_mode <= (m == 1);
      reduced_clock_mode <= (m == 2);
      tick(8);
      rd_chk(`WDT_OFS_COUNT, (m == 2) ? 32'd2 : 32'd0, 1'b0);
    end
    reduced_clock_mode <= 1'b0;
    tick(18);
    rd_chk(`WDT_OFS_COUNT, 32'(TERM), 1'b0);
    tick(1);
    rd_chk(`WDT_OFS_COUNT, 32'd0, 1'b0);
    rd_chk(`WDT_OFS_CTRL, 32'h08, 1'b0);
    chk_bit(timeout_irq_req, 1'b0);
    chk_val(n_rst_req, 32'd0);
    wr(`WDT_OFS_EXT_IRQ_EN, 32'h10);
    settle;
    chk_bit(timeout_irq_req, 1'b1);
    wr(`WDT_OFS_EXT_IRQ_EN, 32'hef);
    settle;
    chk_bit(timeout_irq_req, 1'b0);
    wr(`WDT_OFS_EXT_IRQ_EN, 32'h10);
    chk_bit(irq, 1'b0);
    wr(`WDT_OFS_IRQ_MASK, 32'h1);
    settle;
    chk_bit(irq, 1'b1);
    rd_chk(`WDT_OFS_IRQ_STATUS, 32'h1, 1'b0);
    wr(`WDT_OFS_IRQ_STATUS, 32'h1);
    settle;
    chk_bit(irq, 1'b0);
    wr(`WDT_OFS_CTRL, 32'h08);
    rd_chk(`WDT_OFS_CTRL, 32'h08, 1'b0);
    wr(`WDT_OFS_CTRL, 32'h00);
    settle;
    rd_chk(`WDT_OFS_CTRL, 32'h00, 1'b0);
    chk_bit(timeout_irq_req, 1'b0);
    // Reset-enabled expiry: one request, reset flag recorded
    wr(`WDT_OFS_CTRL, 32'h02);
    // Idle with reset armed: ticks must not count nor fire a reset
    idle_mode <= 1'b1;
    tick(21);
    idle_mode <= 1'b0;
    rd_chk(`WDT_OFS_COUNT, 32'd0, 1'b0);
    chk_val(n_rst_req, 32'd0);
    tick(21);
    settle;
    chk_val(n_rst_req, 32'd1);
    rd_chk(`WDT_OFS_CTRL, 32'h0e, 1'b0);
    rd_chk(`WDT_OFS_IRQ_STATUS, 32'h3, 1'b0);
    wr(`WDT_OFS_IRQ_STATUS, 32'h3);
    rd_chk(`WDT_OFS_IRQ_STATUS, 32'h0, 1'b0);
    wr(`WDT_OFS_CTRL, 32'h0a);
    rd_chk(`WDT_OFS_CTRL, 32'h0a, 1'b0);
    rd_chk(`WDT_OFS_COUNT, 32'd0, 1'b0);
    tick(21);
    settle;
    chk_val(n_rst_req, 32'd2);
    rd_chk(`WDT_OFS_CTRL, 32'h0e, 1'b0);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_chk(`WDT_OFS_CTRL, 32'h0, 1'b0);
    test_done;
  end

  // Cuts a hang short; the tests need well under this span
  initial begin
    #50000;
    n_mismatch++;
    test_done;
  end
endmodule

bind wdt_top wdt_monitor #(.TERMINAL(TERMINAL), .REDUCED_DIV(REDUCED_DIV)) u_mon (
  .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cpu_tick(cpu_tick), .idle_mode(idle_mode), .stop_mode(stop_mode),
  .timeout_irq_req(timeout_irq_req), .sys_reset_req(sys_reset_req), .irq(irq));
`default_nettype wire
